// ===== hdl/sspc_pkg.sv
// Shared constants and carrier types for the sleep, wake and handler priority register group
package sspc_pkg;

  // Word offsets inside the group, byte addresses, all aligned
  localparam logic [7:0] SSPC_OFF_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] SSPC_OFF_CONFIG = 8'h04;
  localparam logic [7:0] SSPC_OFF_PRIO_TWO = 8'h08;
  localparam logic [7:0] SSPC_OFF_PRIO_THREE = 8'h0C;

  // Field positions of the sleep and wake control register
  localparam int SSPC_BIT_WAKE_ANY = 4;
  localparam int SSPC_BIT_DEEP_SLEEP = 2;
  localparam int SSPC_BIT_SLEEP_EXIT = 1;

  // Field positions of the configuration indicator register
  localparam int SSPC_BIT_STACK_ALIGN = 9;
  localparam int SSPC_BIT_UNALIGN_TRAP = 3;

  // Position of the realignment flag in the stacked status word
  localparam int SSPC_BIT_PSW_REALIGN = 9;

  // Priority field placement: top of each field is stored
  localparam int SSPC_PRIO_SVC_LSB = 24;
  localparam int SSPC_PRIO_TICK_LSB = 24;
  localparam int SSPC_PRIO_PEND_LSB = 16;
  localparam int SSPC_PRIO_KEEP_LSB = 6;
  localparam int SSPC_PRIO_KEEP_W = 2;

  // Reset values
  localparam logic [2:0] SSPC_SLEEP_RST = 3'h0;
  localparam logic [1:0] SSPC_PRIO_RST = 2'h0;

  // Low power state of the core
  typedef enum logic [1:0] {
    SSPC_RUN = 2'b00,
    SSPC_WAIT_EVT = 2'b01,
    SSPC_SLEEP = 2'b10
  } sspc_pwr_t;

  // Register request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
  } sspc_req_t;

  // Low power indications towards the clock controller
  typedef struct packed {
    logic sleeping;
    logic deep;
    logic waiting;
  } sspc_pwr_out_t;

  localparam logic [1:0] SSPC_SIZE_WORD = 2'h2;

endpackage

// ===== hdl/sspc_prio_field.sv
// One implemented priority field: two stored bits, the rest zero
`timescale 1ns/10ps
`default_nettype none
module sspc_prio_field #(
  parameter bit IMPL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_byte,
  output logic [7:0] rd_byte
);

  logic [1:0] level_q;

  // Only the top two bits are kept; a missing field stays at zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_q <= sspc_pkg::SSPC_PRIO_RST;
    end else if (wr_en && IMPL) begin
      level_q <= wr_byte[7:6];
    end
  end

  assign rd_byte = {level_q, 6'h00};

endmodule
`default_nettype wire

// ===== hdl/sspc_event_latch.sv
// Sticky event register for the wait-for-event instruction
`timescale 1ns/10ps
`default_nettype none
module sspc_event_latch (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic set_evt,
  input wire logic consume,
  output logic evt_q
);

  // A new event wins over a consume in the same cycle, so none is lost
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evt_q <= 1'b0;
    end else if (set_evt) begin
      evt_q <= 1'b1;
    end else if (consume) begin
      evt_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/sspc_top.sv
// Sleep and wake control, configuration indicator and handler priority registers
// Summary of operation
// - Wake-any-pending clear: only enabled interrupts or events wake the core
// - Wake-any-pending set: enabled events and every interrupt wake the core
// - A newly pending event, or an interrupt that may wake the core, raises the internal event signal
// - An event while not waiting is latched and consumed by next wait
// - Send-event instruction or external event input also wake a waiting core
// - Deep sleep select bit two: zero sleep, one deep sleep
// - Sleep after handler return bit one sleeps on return to thread mode
// - Configuration indicator is read only; writes change nothing
// - Configuration bit nine reads one: eight byte stack alignment
// - Exception entry records realignment in stacked status word bit nine
// - Exception return uses stacked bit nine to restore stack alignment
// - Configuration bit three reads one; unaligned accesses raise hard fault
// - Priority registers hold levels zero to 192 for configurable handlers
// - Priority registers are reached by full word accesses only
// - Each priority field stores bits seven and six; others read zero
// - Second priority register bits 31 to 24 hold supervisor call priority
// - Third priority register bits 31 to 24 hold tick timer priority
// - Third priority register bits 23 to 16 hold pendable service priority
// - Without tick timer its priority field is reserved, not stored
`timescale 1ns/10ps
`default_nettype none
module sspc_top #(
  parameter bit HAS_TICK_TIMER = 1'b1,
  parameter bit HAS_DEEP_SLEEP = 1'b1,
  parameter int NUM_IRQ = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire sspc_pkg::sspc_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_err,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire logic [NUM_IRQ-1:0] irq_enabled,
  input wire logic core_event,
  input wire logic ext_event_pin,
  input wire logic send_event_instr,
  input wire logic wait_for_event_instr,
  input wire logic wait_for_irq_instr,
  input wire logic handler_return_to_thread,
  input wire logic exc_entry,
  input wire logic exc_sp_bit2,
  input wire logic exc_return,
  input wire logic [31:0] stacked_psw,
  input wire logic [31:0] exc_sp,
  input wire logic access_valid,
  input wire logic [1:0] access_addr_lo,
  input wire logic [1:0] access_size,
  output sspc_pkg::sspc_pwr_out_t pwr_state,
  output logic wake_req,
  output logic [31:0] psw_stack_q,
  output logic [31:0] sp_restore_q,
  output logic hard_fault_req,
  output logic [1:0] supervisor_call_priority,
  output logic [1:0] pendable_service_priority,
  output logic [1:0] tick_timer_priority
);

  //////////////////////////////////////////////////////////////////////////////
  // Register group state

  logic wake_on_any_pending_q;
  logic deep_sleep_select_q;
  logic sleep_after_handler_return_q;
  logic word_ok;
  logic wr_two;
  logic wr_three;
  logic [7:0] svc_byte;
  logic [7:0] pend_byte;
  logic [7:0] tick_byte;
  logic [31:0] rdata_d;
  logic err_d;

  // Non-word requests are refused so byte lanes never split a field
  assign word_ok = reg_req.valid && (reg_req.size == sspc_pkg::SSPC_SIZE_WORD) &&
                   (reg_req.addr[1:0] == 2'h0);
  assign wr_two = word_ok && reg_req.write && (reg_req.addr == sspc_pkg::SSPC_OFF_PRIO_TWO);
  assign wr_three = word_ok && reg_req.write &&
                    (reg_req.addr == sspc_pkg::SSPC_OFF_PRIO_THREE);

  // Sleep and wake control bits; reserved positions are never stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_on_any_pending_q <= sspc_pkg::SSPC_SLEEP_RST[2];
      deep_sleep_select_q <= sspc_pkg::SSPC_SLEEP_RST[1];
      sleep_after_handler_return_q <= sspc_pkg::SSPC_SLEEP_RST[0];
    end else if (word_ok && reg_req.write &&
                 (reg_req.addr == sspc_pkg::SSPC_OFF_SLEEP_CTRL)) begin
      wake_on_any_pending_q <= reg_req.wdata[sspc_pkg::SSPC_BIT_WAKE_ANY];
      // Without a second mode the bit is held at zero
      deep_sleep_select_q <= reg_req.wdata[sspc_pkg::SSPC_BIT_DEEP_SLEEP] &
                             HAS_DEEP_SLEEP;
      sleep_after_handler_return_q <= reg_req.wdata[sspc_pkg::SSPC_BIT_SLEEP_EXIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Priority fields

  sspc_prio_field #(.IMPL(1'b1)) u_svc (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_two),
    .wr_byte(reg_req.wdata[sspc_pkg::SSPC_PRIO_SVC_LSB +: 8]),
    .rd_byte(svc_byte)
  );

  sspc_prio_field #(.IMPL(1'b1)) u_pend (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_three),
    .wr_byte(reg_req.wdata[sspc_pkg::SSPC_PRIO_PEND_LSB +: 8]),
    .rd_byte(pend_byte)
  );

  sspc_prio_field #(.IMPL(HAS_TICK_TIMER)) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_three),
    .wr_byte(reg_req.wdata[sspc_pkg::SSPC_PRIO_TICK_LSB +: 8]),
    .rd_byte(tick_byte)
  );

  // Priorities registered toward the exception prioritiser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      supervisor_call_priority <= 2'h0;
      pendable_service_priority <= 2'h0;
      tick_timer_priority <= 2'h0;
    end else begin
      supervisor_call_priority <= svc_byte[7:6];
      pendable_service_priority <= pend_byte[7:6];
      tick_timer_priority <= tick_byte[7:6];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  // Read data and refusal, one cycle after the request
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (reg_req.valid && !word_ok) begin
      err_d = 1'b1;
    end else if (!reg_req.valid) begin
      err_d = 1'b0;
    end else if (reg_req.addr == sspc_pkg::SSPC_OFF_SLEEP_CTRL) begin
      rdata_d[sspc_pkg::SSPC_BIT_WAKE_ANY] = wake_on_any_pending_q;
      rdata_d[sspc_pkg::SSPC_BIT_DEEP_SLEEP] = deep_sleep_select_q;
      rdata_d[sspc_pkg::SSPC_BIT_SLEEP_EXIT] = sleep_after_handler_return_q;
    end else if (reg_req.addr == sspc_pkg::SSPC_OFF_CONFIG) begin
      // Constant bits, so a write here simply has nothing to change
      rdata_d[sspc_pkg::SSPC_BIT_STACK_ALIGN] = 1'b1;
      rdata_d[sspc_pkg::SSPC_BIT_UNALIGN_TRAP] = 1'b1;
    end else if (reg_req.addr == sspc_pkg::SSPC_OFF_PRIO_TWO) begin
      rdata_d[sspc_pkg::SSPC_PRIO_SVC_LSB +: 8] = svc_byte;
    end else if (reg_req.addr == sspc_pkg::SSPC_OFF_PRIO_THREE) begin
      rdata_d[sspc_pkg::SSPC_PRIO_TICK_LSB +: 8] = tick_byte;
      rdata_d[sspc_pkg::SSPC_PRIO_PEND_LSB +: 8] = pend_byte;
    end else begin
      err_d = 1'b1;
    end
  end

  // Reads are only meaningful on the cycle after a read request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_err <= 1'b0;
    end else begin
      reg_rdata <= (reg_req.valid && !reg_req.write) ? rdata_d : 32'h0000_0000;
      reg_err <= err_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Events and wake

  logic ext_sync1_q;
  logic ext_sync2_q;
  logic ext_prev_q;
  logic [NUM_IRQ-1:0] wake_src;
  logic [NUM_IRQ-1:0] wake_prev_q;
  logic new_pend;
  logic evt_set;
  logic evt_q;
  logic irq_wake;
  sspc_pkg::sspc_pwr_t state_q;

  // External event pin comes from outside the clock domain
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_sync1_q <= 1'b0;
      ext_sync2_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_sync1_q <= ext_event_pin;
      ext_sync2_q <= ext_sync1_q;
      ext_prev_q <= ext_sync2_q;
    end
  end

  // Disabled interrupts count only when wake-on-any-pending is set
  generate
    for (genvar i = 0; i < NUM_IRQ; i++) begin : g_src
      assign wake_src[i] = irq_pending[i] & (irq_enabled[i] | wake_on_any_pending_q);
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_prev_q <= '0;
    end else begin
      wake_prev_q <= wake_src;
    end
  end

  // Only a rising pending state makes a fresh event
  assign new_pend = |(wake_src & ~wake_prev_q);
  assign evt_set = new_pend | core_event | send_event_instr |
                   (ext_sync2_q & ~ext_prev_q);
  assign irq_wake = |wake_src;

  // A wait that finds the latch set spends it; an event that wakes a waiting core
  // is used up by that wake, so it cannot make the next wait fall through
  sspc_event_latch u_evt (
    .core_clk(core_clk),
    .rst(rst),
    .set_evt(evt_set && (state_q != sspc_pkg::SSPC_WAIT_EVT)),
    .consume((state_q == sspc_pkg::SSPC_WAIT_EVT) ||
             ((state_q == sspc_pkg::SSPC_RUN) && wait_for_event_instr)),
    .evt_q(evt_q)
  );

  // Power state: wait-for-event, sleep, or running
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= sspc_pkg::SSPC_RUN;
    end else begin
      case (state_q)
        sspc_pkg::SSPC_RUN: begin
          if (wait_for_event_instr && !evt_q) begin
            state_q <= sspc_pkg::SSPC_WAIT_EVT;
          end else if (wait_for_irq_instr ||
                       (handler_return_to_thread && sleep_after_handler_return_q)) begin
            state_q <= sspc_pkg::SSPC_SLEEP;
          end
        end
        sspc_pkg::SSPC_WAIT_EVT: begin
          if (evt_q || evt_set) begin
            state_q <= sspc_pkg::SSPC_RUN;
          end
        end
        sspc_pkg::SSPC_SLEEP: begin
          if (irq_wake || evt_set) begin
            state_q <= sspc_pkg::SSPC_RUN;
          end
        end
        default: begin
          state_q <= sspc_pkg::SSPC_RUN;
        end
      endcase
    end
  end

  // Indications registered so the clock controller sees clean levels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_state <= '0;
      wake_req <= 1'b0;
    end else begin
      pwr_state.sleeping <= (state_q != sspc_pkg::SSPC_RUN);
      pwr_state.deep <= (state_q != sspc_pkg::SSPC_RUN) && deep_sleep_select_q;
      pwr_state.waiting <= (state_q == sspc_pkg::SSPC_WAIT_EVT);
      wake_req <= ((state_q == sspc_pkg::SSPC_WAIT_EVT) && (evt_q || evt_set)) ||
                  ((state_q == sspc_pkg::SSPC_SLEEP) && (irq_wake || evt_set));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stack alignment and unaligned trap

  // Entry records realignment; return undoes the four byte pad
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      psw_stack_q <= 32'h0000_0000;
      sp_restore_q <= 32'h0000_0000;
    end else if (exc_entry) begin
      psw_stack_q <= stacked_psw;
      psw_stack_q[sspc_pkg::SSPC_BIT_PSW_REALIGN] <= exc_sp_bit2;
    end else if (exc_return) begin
      sp_restore_q <= stacked_psw[sspc_pkg::SSPC_BIT_PSW_REALIGN] ?
                      (exc_sp | 32'h0000_0004) : exc_sp;
    end
  end

  // Any misaligned halfword or word access traps
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hard_fault_req <= 1'b0;
    end else begin
      hard_fault_req <= access_valid &&
                        (((access_size == 2'h1) && access_addr_lo[0]) ||
                         ((access_size == 2'h2) && (access_addr_lo != 2'h0)));
    end
  end

endmodule
`default_nettype wire

// ===== tb/sspc_top_properties.sv
// Property checker for the sleep, wake and handler priority register group
`timescale 1ns/10ps
`default_nettype none
module sspc_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire sspc_pkg::sspc_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_err,
  input wire logic send_event_instr,
  input wire logic exc_entry,
  input wire logic exc_sp_bit2,
  input wire logic exc_return,
  input wire logic [31:0] stacked_psw,
  input wire logic [31:0] exc_sp,
  input wire logic access_valid,
  input wire logic [1:0] access_addr_lo,
  input wire logic [1:0] access_size,
  input wire sspc_pkg::sspc_pwr_out_t pwr_state,
  input wire logic wake_req,
  input wire logic [31:0] psw_stack_q,
  input wire logic [31:0] sp_restore_q,
  input wire logic hard_fault_req,
  input wire logic [1:0] supervisor_call_priority
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded requests; word size is the only legal access
  wire logic is_word = reg_req.size == sspc_pkg::SSPC_SIZE_WORD;
  wire logic rd_cfg = reg_req.valid && !reg_req.write && is_word && reg_req.addr == 8'h04;
  wire logic wr_svc = reg_req.valid && reg_req.write && is_word && reg_req.addr == 8'h08;
  // Misaligned data access: word off a word boundary, half off a half boundary
  wire logic unal = access_valid && ((access_size == 2'h2 && access_addr_lo != 2'h0)
                    || (access_size == 2'h1 && access_addr_lo[0]));

  ////////////////////////////////////////////////////////////////////////////////
  a_config_fixed: assert property (rd_cfg |=> reg_rdata == 32'h00000208 && !reg_err)
    else $error("config indicator read wrong");
  a_reserved_zero: assert property ((reg_rdata & 32'h3F3FFDE1) == 32'h0)
    else $error("reserved read bits not zero");
  a_subword_refused: assert property (reg_req.valid && !is_word |=> reg_err)
    else $error("sub-word access not refused");
  a_svc_level: assert property (wr_svc |=> ##1
    supervisor_call_priority == $past(reg_req.wdata[31:30], 2))
    else $error("supervisor call priority not taken");
  a_unaligned_fault: assert property (1'b1 |=> hard_fault_req == $past(unal))
    else $error("hard fault request does not follow alignment");
  a_psw_record: assert property (exc_entry |=> psw_stack_q[9] == $past(exc_sp_bit2)
    && psw_stack_q[8:0] == $past(stacked_psw[8:0]))
    else $error("stacked status word wrong");
  a_sp_restore: assert property (exc_return |=> sp_restore_q == ($past(stacked_psw[9])
    ? ($past(exc_sp) | 32'h4) : $past(exc_sp)))
    else $error("stack pointer restore wrong");
  a_send_wakes: assert property (pwr_state.waiting && !wake_req && send_event_instr
    |=> wake_req ##1 !pwr_state.waiting)
    else $error("send event did not wake");

  ////////////////////////////////////////////////////////////////////////////////
  c_cfg_read: cover property (rd_cfg);
  c_unaligned: cover property (unal);
  c_wake: cover property (pwr_state.waiting ##1 wake_req);
endmodule

bind sspc_top sspc_chk u_chk (.core_clk, .rst, .reg_req, .reg_rdata, .reg_err,
  .send_event_instr, .exc_entry, .exc_sp_bit2, .exc_return, .stacked_psw, .exc_sp,
  .access_valid, .access_addr_lo, .access_size, .pwr_state, .wake_req, .psw_stack_q,
  .sp_restore_q, .hard_fault_req, .supervisor_call_priority);
`default_nettype wire

// ===== tb/tb_system_sleep_priority_control.sv
// Self-checking bench for the sleep, wake and handler priority register group
`timescale 1ns/10ps
`default_nettype none
module tb_system_sleep_priority_control;
  logic core_clk;
  logic rst;
  sspc_pkg::sspc_req_t reg_req;
  sspc_pkg::sspc_pwr_out_t pwr_state;
  logic [31:0] reg_rdata, psw_stack_q, sp_restore_q, stacked_psw, exc_sp, rd, irq_pending, irq_enabled;
  logic reg_err, wake_req, hard_fault_req, ext_event_pin, exc_sp_bit2, access_valid, er, ok;
  logic [1:0] access_addr_lo, access_size, svc_p, pend_p, tick_p;
  logic [6:0] pls;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;

  sspc_top DUT (.core_clk, .rst, .reg_req, .reg_rdata, .reg_err, .irq_pending, .irq_enabled,
    .core_event(pls[0]), .ext_event_pin, .send_event_instr(pls[1]), .wait_for_event_instr(pls[2]),
    .wait_for_irq_instr(pls[3]), .handler_return_to_thread(pls[4]), .exc_entry(pls[5]),
    .exc_sp_bit2, .exc_return(pls[6]), .stacked_psw, .exc_sp, .access_valid, .access_addr_lo,
    .access_size, .pwr_state, .wake_req, .psw_stack_q, .sp_restore_q, .hard_fault_req,
    .supervisor_call_priority(svc_p), .pendable_service_priority(pend_p),
    .tick_timer_priority(tick_p));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the run needs well under a thousand cycles
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  // One register access; the answer is sampled after the taking edge has landed
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] s);
    @(posedge core_clk);
    reg_req <= '{1'b1, w, a, d, s};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
    rd = reg_rdata;
    er = reg_err;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    acc(1'b0, a, 32'h0, 2'h2);
    chk(rd, exp);
    chk(er, experr);
  endtask

  task automatic pulse(input int i);
    @(posedge core_clk);
    pls[i] <= 1'b1;
    @(posedge core_clk);
    pls[i] <= 1'b0;
    #1;
  endtask

  // Power indications are registered, so they follow the state one edge later
  task automatic pchk(input logic [31:0] exp);
    @(posedge core_clk);
    #1;
    chk(pwr_state, exp);
  endtask

  // Bounded wait for the core to be back in run state
  task automatic wait_run();
    ok = 1'b0;
    repeat (8) begin
      @(posedge core_clk);
      #1;
      if (pwr_state === 3'b000) ok = 1'b1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_req = '0;
    pls = '0;
    irq_pending = '0;
    irq_enabled = '0;
    ext_event_pin = 1'b0;
    exc_sp_bit2 = 1'b0;
    stacked_psw = '0;
    exc_sp = '0;
    access_valid = 1'b0;
    access_addr_lo = '0;
    access_size = '0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // Reset state, fixed indicator bits, read-only config
    rchk(8'h00, 32'h0, 1'b0);
    rchk(8'h08, 32'h0, 1'b0);
    rchk(8'h0C, 32'h0, 1'b0);
    rchk(8'h04, 32'h208, 1'b0);
    acc(1'b1, 8'h04, 32'hFFFFFFFF, 2'h2);
    rchk(8'h04, 32'h208, 1'b0);
    acc(1'b1, 8'h00, 32'hFFFFFFFF, 2'h2);
    rchk(8'h00, 32'h16, 1'b0);
    acc(1'b1, 8'h0C, 32'hFFFFFFFF, 2'h2);
    rchk(8'h0C, 32'hC0C00000, 1'b0);
    chk({pend_p, tick_p}, 32'hF);
    // Every level from 0 to 192, low field bits written as ones
    for (int l = 0; l < 4; l++) begin
      acc(1'b1, 8'h08, {l[1:0], 30'h3FFFFFFF}, 2'h2);
      rchk(8'h08, {l[1:0], 30'h0}, 1'b0);
      chk(svc_p, l[1:0]);
    end
    // Byte, half and misaligned word writes are refused; unmapped reads zero
    acc(1'b1, 8'h08, 32'h0, 2'h0);
    chk(er, 1'b1);
    acc(1'b1, 8'h08, 32'h0, 2'h1);
    chk(er, 1'b1);
    acc(1'b1, 8'h09, 32'h0, 2'h2);
    chk(er, 1'b1);
    rchk(8'h08, 32'hC0000000, 1'b0);
    rchk(8'h10, 32'h0, 1'b1);
    // Alignment check for all sizes and byte lanes
    for (int s = 0; s < 3; s++)
      for (int a = 0; a < 4; a++) begin
        @(posedge core_clk);
        access_valid <= 1'b1;
        access_addr_lo <= a[1:0];
        access_size <= s[1:0];
        @(posedge core_clk);
        access_valid <= 1'b0;
        #1;
        chk(hard_fault_req, (s == 2 && a != 0) || (s == 1 && a[0]));
      end
    // Exception entry and return with and without realignment
    @(posedge core_clk);
    stacked_psw <= 32'h80000001;
    exc_sp_bit2 <= 1'b1;
    exc_sp <= 32'h20000FF8;
    pulse(5);
    chk(psw_stack_q, 32'h80000201);
    stacked_psw <= 32'h00000200;
    exc_sp_bit2 <= 1'b0;
    pulse(5);
    chk(psw_stack_q, 32'h0);
    pulse(6);
    chk(sp_restore_q, 32'h20000FFC);
    stacked_psw <= 32'h0;
    pulse(6);
    chk(sp_restore_q, 32'h20000FF8);
    // Wait for event, woken by send event
    acc(1'b1, 8'h00, 32'h0, 2'h2);
    pulse(2);
    pchk(32'h5);
    pulse(1);
    chk(wake_req, 1'b1);
    pchk(32'h0);
    // Events while running are kept, so the next wait does not stall
    pulse(0);
    pulse(2);
    pchk(32'h0);
    pulse(2);
    pchk(32'h5);
    pulse(1);
    pchk(32'h0);
    ext_event_pin <= 1'b1;
    repeat (5) @(posedge core_clk);
    pulse(2);
    pchk(32'h0);
    // Disabled interrupt must not wake unless wake-any is set
    pulse(3);
    pchk(32'h4);
    irq_pending[3] <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk(pwr_state, 32'h4);
    irq_enabled[3] <= 1'b1;
    wait_run();
    chk(ok, 1'b1);
    irq_pending <= '0;
    acc(1'b1, 8'h00, 32'h14, 2'h2);
    pulse(3);
    pchk(32'h6);
    irq_pending[7] <= 1'b1;
    wait_run();
    chk(ok, 1'b1);
    irq_pending <= '0;
    // Sleep on return to thread only while the bit is set
    acc(1'b1, 8'h00, 32'h02, 2'h2);
    pulse(4);
    pchk(32'h4);
    irq_pending[3] <= 1'b1;
    wait_run();
    chk(ok, 1'b1);
    irq_pending <= '0;
    acc(1'b1, 8'h00, 32'h0, 2'h2);
    pulse(4);
    pchk(32'h0);
    summarize();
  end
endmodule
`default_nettype wire
